// File: logic/tcac_chan.v
// One timer channel: value register, write buffer and read-coherency latch
`timescale 1ns/100ps
`default_nettype none
`include "tcac_defines.vh"

module tcac_chan (
  input  wire        clk,
  input  wire        srst,
  input  wire        ce,
  input  wire        debug,
  input  wire        clks_nz,
  input  wire        cpwms,
  input  wire        cnt_tick,
  input  wire        pwm_load,
  input  wire        tsc_wr,
  input  wire        sc_wr,
  input  wire        vh_wr,
  input  wire        vl_wr,
  input  wire        v_rd,
  input  wire        rd_hi,
  input  wire        capture,
  input  wire [7:0]  wdata,
  input  wire [15:0] cnt,
  output wire [7:0]  sc,
  output reg  [7:0]  rbyte
);

  reg  [7:0]  sc_ff;
  reg  [15:0] val_ff;
  reg  [15:0] buf_ff;
  reg  [15:0] lat_ff;
  reg         lat_vld_ff;
  reg         lat_hi_ff;
  reg         got_hi_ff;
  reg         got_lo_ff;
  reg         pend_ff;

  wire [1:0]  ms       = sc_ff[`TCAC_CSC_MS_HI:`TCAC_CSC_MS_LO];
  wire        ic_mode  = ~cpwms & (ms == `TCAC_MS_CAPTURE);
  wire        oc_mode  = ~cpwms & (ms == `TCAC_MS_COMPARE);
  wire        pwm_mode = ~ic_mode & ~oc_mode;
  wire [15:0] nxt_buf  = {vh_wr ? wdata : buf_ff[15:8], vl_wr ? wdata : buf_ff[7:0]};
  wire        v_wr     = (vh_wr | vl_wr) & ~ic_mode;
  wire        pair_done = v_wr & (got_hi_ff | vh_wr) & (got_lo_ff | vl_wr);
  wire        other_byte = lat_vld_ff & (lat_hi_ff != rd_hi);

  assign sc = sc_ff;

  // Read path: live value in debug or on the first byte of a pair, latched partner byte otherwise
  always @* begin
    if (debug) begin
      rbyte = rd_hi ? val_ff[15:8] : val_ff[7:0];
    end else if (other_byte) begin
      rbyte = rd_hi ? lat_ff[15:8] : lat_ff[7:0];
    end else begin
      rbyte = rd_hi ? val_ff[15:8] : val_ff[7:0];
    end
  end

  // Control, value, buffer and latch state
  always @(posedge clk) begin
    if (srst) begin
      sc_ff      <= `TCAC_RST_BYTE;
      val_ff     <= `TCAC_RST_WORD;
      buf_ff     <= `TCAC_RST_WORD;
      lat_ff     <= `TCAC_RST_WORD;
      lat_vld_ff <= 1'b0;
      lat_hi_ff  <= 1'b0;
      got_hi_ff  <= 1'b0;
      got_lo_ff  <= 1'b0;
      pend_ff    <= 1'b0;
    end else if (ce) begin
      if (sc_wr) begin
        sc_ff <= wdata & `TCAC_CSC_MASK;
        if (debug) begin
          lat_vld_ff <= 1'b0;
        end
      end
      // Read coherency only works outside debug halt
      if (v_rd && !debug) begin
        if (other_byte) begin
          lat_vld_ff <= 1'b0;
        end else begin
          lat_vld_ff <= 1'b1;
          lat_hi_ff  <= rd_hi;
          lat_ff     <= val_ff;
        end
      end
      if (tsc_wr) begin
        // Drops a half-written pair and any pending transfer
        got_hi_ff <= 1'b0;
        got_lo_ff <= 1'b0;
        pend_ff   <= 1'b0;
      end else if (v_wr) begin
        buf_ff <= nxt_buf;
        if (pair_done) begin
          got_hi_ff <= 1'b0;
          got_lo_ff <= 1'b0;
          if (clks_nz) begin
            pend_ff <= 1'b1;
          end else begin
            val_ff  <= nxt_buf;
            pend_ff <= 1'b0;
          end
        end else begin
          got_hi_ff <= got_hi_ff | vh_wr;
          got_lo_ff <= got_lo_ff | vl_wr;
        end
      end else if (pend_ff && ((oc_mode && cnt_tick) || (pwm_mode && pwm_load))) begin
        val_ff  <= buf_ff;
        pend_ff <= 1'b0;
      end else if (ic_mode && capture) begin
        val_ff <= cnt;
      end
    end
  end

endmodule // tcac_chan
`default_nettype wire

// File: logic/tcac_defines.vh
// Register map, field layout and reset values of the timer access-coherency block
`ifndef TCAC_DEFINES_VH
`define TCAC_DEFINES_VH

// Byte addresses of the common registers
`define TCAC_ADDR_TSC        8'h00
`define TCAC_ADDR_CNTH       8'h04
`define TCAC_ADDR_CNTL       8'h08
`define TCAC_ADDR_MODH       8'h0C
`define TCAC_ADDR_MODL       8'h10
// Channel n occupies 16 bytes starting at base + 16*n
`define TCAC_CH_BASE_IDX     4'h2
`define TCAC_CH_OFF_SC       4'h0
`define TCAC_CH_OFF_VH       4'h4
`define TCAC_CH_OFF_VL       4'h8

// Timer status/control fields
`define TCAC_TSC_CPWMS       5
`define TCAC_TSC_CLKS_HI     4
`define TCAC_TSC_CLKS_LO     3
`define TCAC_TSC_PS_HI       2
`define TCAC_TSC_PS_LO       0
`define TCAC_TSC_MASK        8'h3F
// Channel status/control fields
`define TCAC_CSC_MS_HI       3
`define TCAC_CSC_MS_LO       2
`define TCAC_CSC_MASK        8'h0F
// Channel mode codes
`define TCAC_MS_CAPTURE      2'h0
`define TCAC_MS_COMPARE      2'h1

// Reset values and the free-running terminal count
`define TCAC_RST_BYTE        8'h00
`define TCAC_RST_WORD        16'h0000
`define TCAC_FREE_TERM       16'hFFFF

`endif

// File: logic/tcac_top.v
// Timer counter with byte-access coherency, reached over APB
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "tcac_defines.vh"

module tcac_top #(
  parameter NCH = 2
) (
  input  wire            CORE_CLK,
  input  wire            SRST,
  input  wire            CLK_EN,
  input  wire            DEBUG_HALT,
  input  wire [NCH-1:0]  CAPTURE_EVT,
  input  wire            PSEL,
  input  wire            PENABLE,
  input  wire            PWRITE,
  input  wire [7:0]      PADDR,
  input  wire [31:0]     PWDATA,
  output reg  [31:0]     PRDATA,
  output reg             PREADY,
  output reg             PSLVERR,
  output reg  [15:0]     COUNT_VALUE
);

  reg  [7:0]  tsc_ff;
  reg  [15:0] mod_ff;
  reg  [6:0]  presc_ff;
  reg  [15:0] clat_ff;
  reg         clat_vld_ff;
  reg         clat_hi_ff;

  // Bus access completes at the edge where PREADY is already high
  wire        done     = PSEL & PENABLE & PREADY;
  wire        wr       = done & PWRITE;
  // Read side effects act at the edge that captures PRDATA, so latch and read data agree
  wire        rd_acc   = PSEL & PENABLE & ~PREADY & ~PWRITE;
  wire [7:0]  wbyte    = PWDATA[7:0];
  wire [3:0]  ch_idx   = PADDR[7:4] - `TCAC_CH_BASE_IDX;
  wire        ch_area  = (PADDR[7:4] >= `TCAC_CH_BASE_IDX) && ({1'b0, ch_idx} < NCH) && (PADDR[1:0] == 2'b00);
  wire        a_tsc    = (PADDR == `TCAC_ADDR_TSC);
  wire        a_cnth   = (PADDR == `TCAC_ADDR_CNTH);
  wire        a_cntl   = (PADDR == `TCAC_ADDR_CNTL);
  wire        a_modh   = (PADDR == `TCAC_ADDR_MODH);
  wire        a_modl   = (PADDR == `TCAC_ADDR_MODL);
  wire        a_csc    = ch_area & (PADDR[3:0] == `TCAC_CH_OFF_SC);
  wire        a_cvh    = ch_area & (PADDR[3:0] == `TCAC_CH_OFF_VH);
  wire        a_cvl    = ch_area & (PADDR[3:0] == `TCAC_CH_OFF_VL);
  wire        mapped   = a_tsc | a_cnth | a_cntl | a_modh | a_modl | a_csc | a_cvh | a_cvl;

  // Counter clocking: prescaler divides by 2 to the power of the select field
  wire [1:0]  clks     = tsc_ff[`TCAC_TSC_CLKS_HI:`TCAC_TSC_CLKS_LO];
  wire        clks_nz  = (clks != 2'b00);
  wire [2:0]  ps       = tsc_ff[`TCAC_TSC_PS_HI:`TCAC_TSC_PS_LO];
  wire [7:0]  div_full = 8'h01 << ps;
  wire [6:0]  div_m1   = div_full[6:0] - 7'h01;
  wire        run      = clks_nz & ~DEBUG_HALT;
  wire        cnt_tick = run & (presc_ff == div_m1);
  wire [15:0] term     = (mod_ff == `TCAC_RST_WORD) ? `TCAC_FREE_TERM : mod_ff;
  wire [15:0] term_m1  = term - 16'h0001;
  wire        pwm_load = cnt_tick & (COUNT_VALUE == term_m1);
  wire        cnt_wr   = wr & (a_cnth | a_cntl);
  wire        c_other  = clat_vld_ff & (clat_hi_ff != a_cnth);

  wire [8*NCH-1:0] ch_rbyte;
  wire [8*NCH-1:0] ch_sc;
  reg  [7:0]       nxt_rbyte;
  reg  [7:0]       ch_rsel;
  reg  [7:0]       ch_scsel;
  integer          k;

  // One channel instance per channel, selected by address nibble
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      wire sel = ch_area & (ch_idx == g);
      tcac_chan u_chan (
        .clk      (CORE_CLK),
        .srst     (SRST),
        .ce       (CLK_EN),
        .debug    (DEBUG_HALT),
        .clks_nz  (clks_nz),
        .cpwms    (tsc_ff[`TCAC_TSC_CPWMS]),
        .cnt_tick (cnt_tick),
        .pwm_load (pwm_load),
        .tsc_wr   (wr & a_tsc),
        .sc_wr    (wr & a_csc & sel),
        .vh_wr    (wr & a_cvh & sel),
        .vl_wr    (wr & a_cvl & sel),
        .v_rd     (rd_acc & (a_cvh | a_cvl) & sel),
        .rd_hi    (a_cvh),
        .capture  (CAPTURE_EVT[g]),
        .wdata    (wbyte),
        .cnt      (COUNT_VALUE),
        .sc       (ch_sc[8*g +: 8]),
        .rbyte    (ch_rbyte[8*g +: 8])
      );
    end
  endgenerate

  // Read data mux; unmapped addresses read zero
  always @* begin
    ch_rsel  = `TCAC_RST_BYTE;
    ch_scsel = `TCAC_RST_BYTE;
    for (k = 0; k < NCH; k = k + 1) begin
      if (ch_idx == k) begin
        ch_rsel  = ch_rbyte[8*k +: 8];
        ch_scsel = ch_sc[8*k +: 8];
      end
    end
    if (a_tsc) begin
      nxt_rbyte = tsc_ff;
    end else if (a_cnth || a_cntl) begin
      if (!DEBUG_HALT && c_other) begin
        nxt_rbyte = a_cnth ? clat_ff[15:8] : clat_ff[7:0];
      end else begin
        nxt_rbyte = a_cnth ? COUNT_VALUE[15:8] : COUNT_VALUE[7:0];
      end
    end else if (a_modh) begin
      nxt_rbyte = mod_ff[15:8];
    end else if (a_modl) begin
      nxt_rbyte = mod_ff[7:0];
    end else if (a_csc) begin
      nxt_rbyte = ch_scsel;
    end else if (a_cvh || a_cvl) begin
      nxt_rbyte = ch_rsel;
    end else begin
      nxt_rbyte = `TCAC_RST_BYTE;
    end
  end

  // APB answer: one wait state, ready raised on the second access cycle
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else if (CLK_EN) begin
      PREADY <= PSEL & PENABLE & ~PREADY;
      if (PSEL && PENABLE && !PREADY) begin
        PSLVERR <= ~mapped;
        PRDATA  <= PWRITE ? 32'h00000000 : {24'h000000, nxt_rbyte};
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // Timer control and modulus registers
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      tsc_ff <= `TCAC_RST_BYTE;
      mod_ff <= `TCAC_RST_WORD;
    end else if (CLK_EN && wr) begin
      if (a_tsc) begin
        tsc_ff <= wbyte & `TCAC_TSC_MASK;
      end
      if (a_modh) begin
        mod_ff[15:8] <= wbyte;
      end
      if (a_modl) begin
        mod_ff[7:0] <= wbyte;
      end
    end
  end

  // Main counter and prescaler; a counter write wins over counting
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      COUNT_VALUE <= `TCAC_RST_WORD;
      presc_ff    <= 7'h00;
    end else if (CLK_EN) begin
      if (cnt_wr) begin
        COUNT_VALUE <= `TCAC_RST_WORD;
        presc_ff    <= 7'h00;
      end else if (run) begin
        if (cnt_tick) begin
          presc_ff    <= 7'h00;
          COUNT_VALUE <= (COUNT_VALUE >= term) ? `TCAC_RST_WORD : COUNT_VALUE + 16'h0001;
        end else begin
          presc_ff <= presc_ff + 7'h01;
        end
      end
    end
  end

  // Counter read-coherency latch
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      clat_ff     <= `TCAC_RST_WORD;
      clat_vld_ff <= 1'b0;
      clat_hi_ff  <= 1'b0;
    end else if (CLK_EN) begin
      if (cnt_wr) begin
        // Clears a half-read pair in any state
        clat_vld_ff <= 1'b0;
      end else if (wr && a_tsc && DEBUG_HALT) begin
        clat_vld_ff <= 1'b0;
      end else if (rd_acc && (a_cnth || a_cntl) && !DEBUG_HALT) begin
        if (c_other) begin
          clat_vld_ff <= 1'b0;
        end else begin
          clat_vld_ff <= 1'b1;
          clat_hi_ff  <= a_cnth;
          clat_ff     <= COUNT_VALUE;
        end
      end
    end
  end

endmodule // tcac_top
`default_nettype wire

// File: testbench/tcac_monitor.sv
// Bus and counter checks on the timer block ports
`timescale 1ns/100ps
`default_nettype none
module tcac_monitor #(
  parameter NCH = 2
) (
  input wire logic           CORE_CLK,
  input wire logic           SRST,
  input wire logic           CLK_EN,
  input wire logic           DEBUG_HALT,
  input wire logic [NCH-1:0] CAPTURE_EVT,
  input wire logic           PSEL,
  input wire logic           PENABLE,
  input wire logic           PWRITE,
  input wire logic [7:0]     PADDR,
  input wire logic [31:0]    PWDATA,
  input wire logic [31:0]    PRDATA,
  input wire logic           PREADY,
  input wire logic           PSLVERR,
  input wire logic [15:0]    COUNT_VALUE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  // Completed write to either counter byte
  wire logic cnt_wr = CLK_EN && PSEL && PENABLE && PREADY && PWRITE && (PADDR == 8'h04 || PADDR == 8'h08);
  sequence wait_s;
    PSEL && PENABLE && !PREADY;
  endsequence
  // Decoded addresses; offset 0xC inside a channel is a hole
  function automatic logic mapped(input logic [7:0] a);
    mapped = a[1:0] == 2'h0 && (a <= 8'h10 || (a[7:4] >= 4'h2 && a[7:4] < 4'(2 + NCH) && a[3:2] != 2'h3));
  endfunction
  wait_state_a: assert property (PSEL && !PENABLE && CLK_EN |=> wait_s ##1 PREADY) else $error("wait state wrong");
  ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready held");
  slave_err_a: assert property (PREADY |-> PSLVERR == !mapped(PADDR)) else $error("slave error wrong");
  upper_zero_a: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0) else $error("upper bits set");
  cnt_clear_a: assert property (cnt_wr |=> COUNT_VALUE == 16'h0000) else $error("count not cleared");
  dbg_freeze_a:
    assert property (DEBUG_HALT && $past(DEBUG_HALT) && !cnt_wr |=> $stable(COUNT_VALUE))
      else $error("count moved in debug");
  dbg_read_a:
    assert property (PREADY && !PWRITE && PADDR == 8'h04 && DEBUG_HALT && $past(DEBUG_HALT, 3)
      |-> PRDATA[7:0] == COUNT_VALUE[15:8]) else $error("debug read not frozen count");
  enable_hold_a: assert property (!CLK_EN |=> $stable(COUNT_VALUE) && $stable(PREADY)) else $error("moved while off");
endmodule // tcac_monitor

bind tcac_top tcac_monitor #(.NCH(NCH)) i_mon (.CORE_CLK(CORE_CLK), .SRST(SRST), .CLK_EN(CLK_EN),
  .DEBUG_HALT(DEBUG_HALT), .CAPTURE_EVT(CAPTURE_EVT), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .COUNT_VALUE(COUNT_VALUE));
`default_nettype wire

// File: testbench/test_timer_counter_access_coherency.sv
// Self-checking bench for the timer access-coherency block
`timescale 1ns/100ps
`default_nettype none
module test_timer_counter_access_coherency;
  logic             core_clk = 1'b0;
  logic             srst = 1'b1;
  logic             clk_en = 1'b1;
  logic             debug_halt = 1'b0;
  logic [1:0]       capture_evt = 2'h0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  wire logic [31:0] prdata;
  wire logic        pready;
  wire logic        pslverr;
  wire logic [15:0] count_value;
  logic [31:0]      rd;
  logic             err;
  logic [15:0]      held;
  int               errors = 0;
  int               check_count = 0;
  // Rows: address, written, read back, slave error
  logic [31:0] rows [7] = '{32'h00C70700, 32'h0C121200, 32'h10343400, 32'h20F40400,
    32'h30F00000, 32'h14550001, 32'h2C550001};

  tcac_top i_dut (.CORE_CLK(core_clk), .SRST(srst), .CLK_EN(clk_en), .DEBUG_HALT(debug_halt),
    .CAPTURE_EVT(capture_evt), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .COUNT_VALUE(count_value));

  // 40 MHz core clock
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // One transfer; the request stands until ready is seen, then drops
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // Ready is sampled at the rising edge, where the slave sees the request too
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 9);
    if (pready !== 1'b1) begin
      errors++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk("read byte", {24'h0, exp}, rd);
  endtask

  task automatic stop_test;
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog, several times the expected run length
  initial begin
    #250000;
    errors++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, rows[i][31:24], rows[i][23:16]);
      rc(rows[i][31:24], rows[i][15:8]);
      chk("slave error", {31'h0, rows[i][0]}, {31'h0, err});
    end
    // Capture channel ignores value writes
    apb(1'b1, 8'h34, 8'h99);
    apb(1'b1, 8'h38, 8'h99);
    rc(8'h34, 8'h00);
    // Stopped clock loads at once; a control write drops a half pair
    apb(1'b1, 8'h24, 8'h12);
    apb(1'b1, 8'h28, 8'h34);
    apb(1'b1, 8'h24, 8'hAA);
    apb(1'b1, 8'h00, 8'h07);
    apb(1'b1, 8'h28, 8'hBB);
    rc(8'h24, 8'h12);
    rc(8'h28, 8'h34);
    // Debug reads are live; channel control write in debug drops the latch
    apb(1'b1, 8'h00, 8'h07);
    rc(8'h24, 8'h12);
    apb(1'b1, 8'h24, 8'h56);
    apb(1'b1, 8'h28, 8'h78);
    debug_halt <= 1'b1;
    rc(8'h28, 8'h78);
    apb(1'b1, 8'h20, 8'h04);
    debug_halt <= 1'b0;
    rc(8'h28, 8'h78);
    // Buffered compare value waits for the counter to step
    apb(1'b1, 8'h00, 8'h0F);
    repeat (120) @(posedge core_clk);
    apb(1'b1, 8'h08, 8'h00);
    apb(1'b1, 8'h24, 8'h9A);
    apb(1'b1, 8'h28, 8'hBC);
    rc(8'h28, 8'h78);
    chk("count", 32'h0, {16'h0, count_value});
    repeat (300) if (count_value === 16'h0000) @(posedge core_clk);
    rc(8'h28, 8'hBC);
    // Running counter: byte latch, and a counter write drops it
    apb(1'b1, 8'h00, 8'h08);
    apb(1'b1, 8'h08, 8'h00);
    repeat (40) @(posedge core_clk);
    rc(8'h04, 8'h00);
    repeat (350) @(posedge core_clk);
    apb(1'b0, 8'h08, 8'h00);
    chk("held low", 32'h1, {31'h0, rd >= 32'h20 && rd < 32'h50});
    apb(1'b0, 8'h04, 8'h00);
    repeat (60) @(posedge core_clk);
    apb(1'b1, 8'h04, 8'hFF);
    apb(1'b0, 8'h08, 8'h00);
    chk("fresh low", 32'h1, {31'h0, rd < 32'h10});
    // Debug freezes reads; a control write there drops the counter latch
    repeat (300) @(posedge core_clk);
    debug_halt <= 1'b1;
    apb(1'b1, 8'h00, 8'h08);
    rc(8'h04, 8'h01);
    apb(1'b0, 8'h08, 8'h00);
    held = rd[15:0];
    // Capture of the frozen count; a debug read of the high byte returns it live
    capture_evt <= 2'h2;
    @(posedge core_clk);
    capture_evt <= 2'h0;
    rc(8'h34, 8'h01);
    repeat (40) @(posedge core_clk);
    rc(8'h08, held[7:0]);
    debug_halt <= 1'b0;
    rc(8'h04, 8'h01);
    // Enable low holds the count
    clk_en <= 1'b0;
    repeat (2) @(posedge core_clk);
    held = count_value;
    repeat (20) @(posedge core_clk);
    chk("held count", {16'h0, held}, {16'h0, count_value});
    clk_en <= 1'b1;
    // Edge PWM loads only on the step into the terminal count
    apb(1'b1, 8'h0C, 8'h00);
    apb(1'b1, 8'h10, 8'hFF);
    apb(1'b1, 8'h30, 8'h08);
    apb(1'b1, 8'h08, 8'h00);
    apb(1'b1, 8'h34, 8'h11);
    apb(1'b1, 8'h38, 8'h22);
    rc(8'h34, 8'h01);
    repeat (300) if (count_value !== 16'h00FF) @(posedge core_clk);
    rc(8'h34, 8'h11);
    // Reset in mid-run
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rc(8'h00, 8'h00);
    rc(8'h24, 8'h00);
    chk("reset count", 32'h0, {16'h0, count_value});
    stop_test();
  end
endmodule // test_timer_counter_access_coherency
`default_nettype wire
